// file: src/cfg_decoder_params.svh
// configuration word decoder: addresses, field positions and erased value
`ifndef CFG_DECODER_PARAMS_SVH
`define CFG_DECODER_PARAMS_SVH

// ==========================================================
// table addresses of the configuration words
`define CFG_ADDR_W 24
`define CFG_ADDR_OSC_SEL 24'hF80006
`define CFG_ADDR_OSC 24'hF80008
`define CFG_ADDR_WDT 24'hF8000A
`define CFG_ADDR_RST 24'hF8000C
`define CFG_ADDR_DBG 24'hF8000E

// ==========================================================
// word indices in the storage array
`define CFG_IDX_OSC_SEL 3'h0
`define CFG_IDX_OSC 3'h1
`define CFG_IDX_WDT 3'h2
`define CFG_IDX_RST 3'h3
`define CFG_IDX_DBG 3'h4
`define CFG_NUM_WORDS 5

// ==========================================================
// implemented-bit masks and erased value
`define CFG_MASK_OSC_SEL 8'hE7
`define CFG_MASK_OSC 8'hFF
`define CFG_MASK_WDT 8'hFF
`define CFG_MASK_RST 8'hFF
`define CFG_MASK_DBG 8'h83
`define CFG_ERASED 8'hFF

// ==========================================================
// field positions
`define OSEL_TWO_SPEED 7
`define OSEL_SLOW_RC_PWR 6
`define OSEL_SEC_SRC 5
`define OSEL_INIT_OSC_HI 2
`define OSC_SWITCH_HI 7
`define OSC_SWITCH_LO 6
`define OSC_SEC_PWR 5
`define OSC_FREQ_HI 4
`define OSC_FREQ_LO 3
`define OSC_CLKOUT 2
`define OSC_PMODE_HI 1
`define WDT_EN_HI 7
`define WDT_WIN_DIS 6
`define WDT_EN_LO 5
`define WDT_PRESCALE 4
`define WDT_POST_HI 3
`define RST_PIN_EN 7
`define RST_BOR_LVL_HI 6
`define RST_BOR_LVL_LO 5
`define RST_I2C_MAP 4
`define RST_PWRUP 3
`define RST_RETENTION 2
`define RST_BOR_EN_HI 1
`define DBG_DEBUG_N 7
`define DBG_PAIR_HI 1

`endif

// file: src/cfg_decoder_pkg.sv
// configuration word decoder: shared types
package cfg_decoder_pkg;
  typedef enum logic [2:0] {
    OSC_FAST_RC = 3'h0,
    OSC_FAST_RC_DIV_PLL = 3'h1,
    OSC_PRIMARY = 3'h2,
    OSC_PRIMARY_PLL = 3'h3,
    OSC_SECONDARY = 3'h4,
    OSC_SLOW_RC = 3'h5,
    OSC_LP_FAST_RC_DIV = 3'h6,
    OSC_FAST_RC_DIV = 3'h7
  } osc_select_type;

  typedef enum logic [1:0] {
    PMODE_EXT_CLK = 2'h0,
    PMODE_STD_XTAL = 2'h1,
    PMODE_HS_XTAL = 2'h2,
    PMODE_DISABLED = 2'h3
  } prim_mode_type;
endpackage

// file: src/config_word_decoder.sv
// configuration word storage, table access and decoded settings
// Function
// - switchover bit enables two-speed start-up
// - slow RC power bit selects accuracy mode
// - secondary source bit selects crystal or digital
// - three-bit field picks initial oscillator
// - clock switch field gates switching, fail-safe
// - secondary oscillator power bit selects power
// - primary frequency range field, 00 reserved
// - clock output only in disabled/external modes
// - primary mode field selects oscillator mode
// - watchdog enable pair selects hw/sw control
// - window bit; cleared disabled watchdog never resets
// - prescaler bit picks 1:128 or 1:32
// - postscale ratio is two to field
// - reset pin enable selects reset or input
// - brown-out level field selects trip voltage
// - I2C map bit picks default/alternate pins
// - power-up timer bit enables delay timer
// - retention bit gates runtime retention control
// - brown-out enable field selects hw/sw control
// - debugger enable bit is active low
// - debug pin pair field, 00 reserved
// - reset pin bit programs only in high-voltage entry; bulk erase sets it in any mode
// - unimplemented bits zero, erased bits one
// - programmed reads zero, table access only
`timescale 1ns/1ns
`include "cfg_decoder_params.svh"

module config_word_decoder (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rst,
  // table read/write port
  input wire logic i_tbl_rd,
  input wire logic i_tbl_wr,
  input wire logic [23:0] i_tbl_addr,
  input wire logic [7:0] i_tbl_wdata,
  output logic [7:0] o_tbl_rdata,
  output logic o_tbl_ack,
  // programmer
  input wire logic i_bulk_erase,
  input wire logic i_hv_prog_entry,
  // runtime controls
  input wire logic i_sleep,
  input wire logic i_watchdog_sw_enable,
  input wire logic i_watchdog_clear_instr,
  input wire logic i_watchdog_window_open,
  input wire logic i_brownout_sw_enable,
  input wire logic i_retention_runtime_en,
  input wire logic i_shared_input_pin,
  // oscillator settings
  output logic o_two_speed_startup_en,
  output logic o_slow_rc_high_power,
  output logic o_secondary_crystal_en,
  output logic o_secondary_digital_clk_in_sel,
  output cfg_decoder_pkg::osc_select_type o_initial_osc_select,
  output logic o_clock_switch_en,
  output logic o_fail_safe_monitor_en,
  output logic o_secondary_osc_high_power,
  output logic [1:0] o_primary_freq_range,
  output logic o_primary_freq_invalid,
  output logic o_clock_out_en,
  output cfg_decoder_pkg::prim_mode_type o_primary_osc_mode,
  // watchdog settings
  output logic o_watchdog_run,
  output logic o_watchdog_sw_ctrl,
  output logic o_watchdog_windowed,
  output logic o_watchdog_prescale_128,
  output logic [3:0] o_watchdog_postscale_sel,
  output logic [15:0] o_watchdog_postscale_div,
  output logic o_watchdog_clear_reset,
  // reset and power settings
  output logic o_reset_pin_enable,
  output logic o_master_reset_req,
  output logic o_shared_input_val,
  output logic [1:0] o_brownout_level_sel,
  output logic o_brownout_zero_power,
  output logic o_brownout_run,
  output logic o_brownout_sw_ctrl,
  output logic o_i2c_alt_pins,
  output logic o_powerup_timer_en,
  output logic o_retention_avail,
  output logic o_retention_active,
  // debugger settings
  output logic o_debug_en,
  output logic [2:0] o_prog_pin_pair_sel,
  output logic o_debug_pin_invalid
);
  import cfg_decoder_pkg::*;

  // ==========================================================
  // pin synchronisers
  logic hv_meta_r;
  logic hv_sync_r;
  logic pin_meta_r;
  logic pin_sync_r;

  always_ff @(posedge i_mclk)
  begin
    hv_meta_r <= i_hv_prog_entry;
    hv_sync_r <= hv_meta_r;
    pin_meta_r <= i_shared_input_pin;
    pin_sync_r <= pin_meta_r;
  end

  // ==========================================================
  // address decode
  logic [2:0] word_idx;
  logic word_hit;

  always_comb
  begin
    word_idx = `CFG_IDX_OSC_SEL;
    word_hit = 1'b1;
    if (i_tbl_addr == `CFG_ADDR_OSC_SEL)
      word_idx = `CFG_IDX_OSC_SEL;
    else if (i_tbl_addr == `CFG_ADDR_OSC)
      word_idx = `CFG_IDX_OSC;
    else if (i_tbl_addr == `CFG_ADDR_WDT)
      word_idx = `CFG_IDX_WDT;
    else if (i_tbl_addr == `CFG_ADDR_RST)
      word_idx = `CFG_IDX_RST;
    else if (i_tbl_addr == `CFG_ADDR_DBG)
      word_idx = `CFG_IDX_DBG;
    else
      word_hit = 1'b0;
  end

  // ==========================================================
  // configuration storage
  // programming only clears bits; erase is the only way back to one
  localparam logic [7:0] IMPL_MASK [0:`CFG_NUM_WORDS-1] = '{
    `CFG_MASK_OSC_SEL, `CFG_MASK_OSC, `CFG_MASK_WDT, `CFG_MASK_RST, `CFG_MASK_DBG};
  logic [7:0] cfg_mem_r [0:`CFG_NUM_WORDS-1];
  logic [7:0] lat_r [0:`CFG_NUM_WORDS-1];

  genvar gw;
  generate
    for (gw = 0; gw < `CFG_NUM_WORDS; gw++)
    begin : g_word
      logic [7:0] keep_mask;
      logic sel;
      assign sel = word_hit && (word_idx == 3'(gw));
      // reset pin bit is frozen unless high-voltage entry is active
      assign keep_mask = (gw == `CFG_IDX_RST && !hv_sync_r) ? 8'h80 : 8'h00;

      always_ff @(posedge i_mclk)
      begin
        if (i_bulk_erase)
          cfg_mem_r[gw] <= `CFG_ERASED & IMPL_MASK[gw];
        else if (i_tbl_wr && sel)
          cfg_mem_r[gw] <= cfg_mem_r[gw] & (i_tbl_wdata | keep_mask) & IMPL_MASK[gw];
      end

      // settings follow storage only while reset is held
      always_ff @(posedge i_mclk)
      begin
        if (i_rst)
          lat_r[gw] <= cfg_mem_r[gw] & IMPL_MASK[gw];
      end
    end
  endgenerate

  // ==========================================================
  // table read response
  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
    begin
      o_tbl_rdata <= 8'h00;
      o_tbl_ack <= 1'b0;
    end
    else
    begin
      o_tbl_ack <= i_tbl_rd || i_tbl_wr;
      if (i_tbl_rd && word_hit)
        o_tbl_rdata <= cfg_mem_r[word_idx] & IMPL_MASK[word_idx];
      else if (i_tbl_rd)
        o_tbl_rdata <= 8'h00;
    end
  end

  // ==========================================================
  // oscillator decode
  logic [7:0] osel;
  logic [7:0] oscw;
  assign osel = lat_r[`CFG_IDX_OSC_SEL];
  assign oscw = lat_r[`CFG_IDX_OSC];

  always_ff @(posedge i_mclk)
  begin
    o_two_speed_startup_en <= osel[`OSEL_TWO_SPEED];
    o_slow_rc_high_power <= osel[`OSEL_SLOW_RC_PWR];
    o_secondary_crystal_en <= osel[`OSEL_SEC_SRC];
    o_secondary_digital_clk_in_sel <= !osel[`OSEL_SEC_SRC];
    o_initial_osc_select <= osc_select_type'(osel[`OSEL_INIT_OSC_HI:0]);
    o_clock_switch_en <= !oscw[`OSC_SWITCH_HI];
    o_fail_safe_monitor_en <= !oscw[`OSC_SWITCH_HI] && !oscw[`OSC_SWITCH_LO];
    o_secondary_osc_high_power <= oscw[`OSC_SEC_PWR];
    o_primary_freq_range <= oscw[`OSC_FREQ_HI:`OSC_FREQ_LO];
    o_primary_freq_invalid <= oscw[`OSC_FREQ_HI:`OSC_FREQ_LO] == 2'h0;
    o_primary_osc_mode <= prim_mode_type'(oscw[`OSC_PMODE_HI:0]);
  end

  // a crystal on the pin would fight the clock driver, so gate by mode
  always_ff @(posedge i_mclk)
  begin
    o_clock_out_en <= oscw[`OSC_CLKOUT] &&
      (oscw[`OSC_PMODE_HI:0] == 2'h3 || oscw[`OSC_PMODE_HI:0] == 2'h0);
  end

  // ==========================================================
  // watchdog decode
  logic [7:0] wdtw;
  logic [1:0] wdt_en_pair;
  logic wdt_run_nxt;
  assign wdtw = lat_r[`CFG_IDX_WDT];
  assign wdt_en_pair = {wdtw[`WDT_EN_HI], wdtw[`WDT_EN_LO]};

  always_comb
  begin
    case (wdt_en_pair)
      2'h3: wdt_run_nxt = 1'b1;
      2'h2: wdt_run_nxt = i_watchdog_sw_enable;
      2'h1: wdt_run_nxt = !i_sleep;
      default: wdt_run_nxt = 1'b0;
    endcase
  end

  always_ff @(posedge i_mclk)
  begin
    o_watchdog_run <= wdt_run_nxt;
    o_watchdog_sw_ctrl <= wdt_en_pair == 2'h2;
    o_watchdog_windowed <= !wdtw[`WDT_WIN_DIS];
    o_watchdog_prescale_128 <= wdtw[`WDT_PRESCALE];
    o_watchdog_postscale_sel <= wdtw[`WDT_POST_HI:0];
    o_watchdog_postscale_div <= 16'h0001 << wdtw[`WDT_POST_HI:0];
  end

  // early clear in windowed mode resets; a stopped watchdog never does
  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
      o_watchdog_clear_reset <= 1'b0;
    else
      o_watchdog_clear_reset <= i_watchdog_clear_instr && !wdtw[`WDT_WIN_DIS] &&
        !i_watchdog_window_open && wdt_run_nxt;
  end

  // ==========================================================
  // reset and power decode
  logic [7:0] rstw;
  logic [1:0] bor_en;
  logic bor_run_nxt;
  assign rstw = lat_r[`CFG_IDX_RST];
  assign bor_en = rstw[`RST_BOR_EN_HI:0];

  always_comb
  begin
    case (bor_en)
      2'h3: bor_run_nxt = 1'b1;
      2'h2: bor_run_nxt = !i_sleep;
      2'h1: bor_run_nxt = i_brownout_sw_enable;
      default: bor_run_nxt = 1'b0;
    endcase
  end

  always_ff @(posedge i_mclk)
  begin
    o_reset_pin_enable <= rstw[`RST_PIN_EN];
    o_brownout_level_sel <= rstw[`RST_BOR_LVL_HI:`RST_BOR_LVL_LO];
    o_brownout_zero_power <= rstw[`RST_BOR_LVL_HI:`RST_BOR_LVL_LO] == 2'h0;
    o_brownout_run <= bor_run_nxt;
    o_brownout_sw_ctrl <= bor_en == 2'h1;
    o_i2c_alt_pins <= !rstw[`RST_I2C_MAP];
    o_powerup_timer_en <= rstw[`RST_PWRUP];
    o_retention_avail <= !rstw[`RST_RETENTION];
    o_retention_active <= !rstw[`RST_RETENTION] && i_retention_runtime_en && i_sleep;
  end

  // shared pin: active-low reset or plain input, never both
  always_ff @(posedge i_mclk)
  begin
    o_master_reset_req <= rstw[`RST_PIN_EN] && !pin_sync_r;
    o_shared_input_val <= !rstw[`RST_PIN_EN] && pin_sync_r;
  end

  // ==========================================================
  // debugger decode
  logic [7:0] dbgw;
  assign dbgw = lat_r[`CFG_IDX_DBG];

  always_ff @(posedge i_mclk)
  begin
    o_debug_en <= !dbgw[`DBG_DEBUG_N];
    o_prog_pin_pair_sel <= {dbgw[`DBG_PAIR_HI:0] == 2'h1, dbgw[`DBG_PAIR_HI:0] == 2'h2,
      dbgw[`DBG_PAIR_HI:0] == 2'h3};
    o_debug_pin_invalid <= dbgw[`DBG_PAIR_HI:0] == 2'h0;
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);

  logic past_run_ok;
  always_ff @(posedge i_mclk)
  begin
    past_run_ok <= !i_rst;
  end

  chk_settings_hold: assert property (past_run_ok |-> ##1 $stable(o_initial_osc_select) &&
    $stable(o_primary_osc_mode) && $stable(o_reset_pin_enable))
    else $error("settings changed after reset");
  chk_clkout_mode: assert property (o_clock_out_en |->
    o_primary_osc_mode == PMODE_DISABLED || o_primary_osc_mode == PMODE_EXT_CLK)
    else $error("clock output with crystal mode");
  chk_failsafe_switch: assert property (o_fail_safe_monitor_en |-> o_clock_switch_en)
    else $error("fail-safe without switching");
  chk_wdt_clear_reset: assert property (o_watchdog_clear_reset |->
    $past(wdt_run_nxt) && o_watchdog_windowed)
    else $error("clear reset while watchdog stopped");
  chk_wdt_postscale: assert property (past_run_ok |->
    o_watchdog_postscale_div == (16'h0001 << o_watchdog_postscale_sel))
    else $error("postscale ratio mismatch");
  chk_reset_pin_excl: assert property (!(o_master_reset_req && o_shared_input_val))
    else $error("shared pin used both ways");
  chk_master_reset_pin_lock: assert property (i_tbl_wr && i_tbl_addr == `CFG_ADDR_RST && !hv_sync_r &&
    !i_bulk_erase |=> $stable(cfg_mem_r[`CFG_IDX_RST][`RST_PIN_EN]))
    else $error("reset pin bit changed outside hv entry");
  chk_unimpl_zero: assert property (i_tbl_rd && i_tbl_addr == `CFG_ADDR_DBG |=>
    o_tbl_ack && o_tbl_rdata[6:2] == 5'h00)
    else $error("unimplemented bits read nonzero");
  chk_prog_clears: assert property (i_tbl_wr && word_hit && !i_bulk_erase |=>
    (cfg_mem_r[$past(word_idx)] & ~$past(cfg_mem_r[word_idx])) == 8'h00)
    else $error("programming set a bit");
  chk_bor_off: assert property (o_brownout_run |-> $past(bor_en) != 2'h0)
    else $error("brown-out ran while disabled");
  chk_debug_pair: assert property (o_debug_pin_invalid |-> o_prog_pin_pair_sel == 3'h0)
    else $error("pin pair selected for reserved code");

  cov_table_read: cover property (i_tbl_rd && word_hit ##1 o_tbl_ack);
  cov_clear_reset: cover property (o_watchdog_clear_reset);
  cov_clock_out: cover property (o_clock_out_en);
  cov_master_reset: cover property (o_master_reset_req);
endmodule // config_word_decoder

// file: verif/cfg_programmer_model.sv
// programmer model: table accesses, bulk erase and high-voltage entry
`timescale 1ns/1ns

module cfg_programmer_model (
  // clock
  input wire logic i_mclk,
  // table port
  output logic o_tbl_rd,
  output logic o_tbl_wr,
  output logic [23:0] o_tbl_addr,
  output logic [7:0] o_tbl_wdata,
  input wire logic [7:0] i_tbl_rdata,
  input wire logic i_tbl_ack,
  // programming pins
  output logic o_bulk_erase,
  output logic o_hv_prog_entry
);
  initial
  begin
    {o_tbl_rd, o_tbl_wr, o_bulk_erase, o_hv_prog_entry} = 4'h0;
    o_tbl_addr = 24'h000000;
    o_tbl_wdata = 8'h00;
  end

  // ==========================================================
  // table access; gap idles first to act as a slow programmer
  task automatic access(input logic wr, input logic [23:0] addr, input logic [7:0] wdata,
    input int gap, output logic [7:0] rdata, output logic ack);
    repeat (gap + 1) @(negedge i_mclk);
    o_tbl_rd <= !wr;
    o_tbl_wr <= wr;
    o_tbl_addr <= addr;
    o_tbl_wdata <= wdata;
    @(negedge i_mclk);
    ack = i_tbl_ack;
    rdata = i_tbl_rdata;
    // released lines flip so a stale address never looks held
    o_tbl_rd <= 1'b0;
    o_tbl_wr <= 1'b0;
    o_tbl_addr <= ~addr;
    o_tbl_wdata <= ~wdata;
  endtask

  // ==========================================================
  // erase and high-voltage entry
  task automatic erase();
    @(negedge i_mclk);
    o_bulk_erase <= 1'b1;
    @(negedge i_mclk);
    o_bulk_erase <= 1'b0;
  endtask

  // 3 cycles cover the two-stage sync of the entry pin
  task automatic set_hv(input logic level);
    @(negedge i_mclk);
    o_hv_prog_entry <= level;
    repeat (3) @(negedge i_mclk);
  endtask
endmodule // cfg_programmer_model

// file: verif/config_word_decoder_bench.sv
// self-checking bench for the configuration word decoder
`timescale 1ns/1ns

module config_word_decoder_bench;
  // ==========================================================
  // signals and case table
  logic i_mclk, i_rst, i_tbl_rd, i_tbl_wr, i_bulk_erase, i_hv_prog_entry, o_tbl_ack;
  logic i_sleep, i_watchdog_sw_enable, i_watchdog_clear_instr, i_watchdog_window_open;
  logic i_brownout_sw_enable, i_retention_runtime_en, i_shared_input_pin, o_clock_out_en;
  logic o_secondary_digital_clk_in_sel, o_watchdog_clear_reset, o_master_reset_req;
  logic o_shared_input_val;
  logic [23:0] i_tbl_addr;
  logic [7:0] i_tbl_wdata, o_tbl_rdata;
  logic [2:0] o_initial_osc_select, o_prog_pin_pair_sel;
  logic [1:0] o_primary_freq_range, o_primary_osc_mode;
  logic [15:0] o_watchdog_postscale_div;
  wire [12:0] fl;
  wire [2:0] bor;
  wire [1:0] sw, run, ctl;
  wire ret_act;
  wire [3:0] psel;
  int n_mismatch = 0;
  int tests_run = 0;
  typedef struct packed {
    logic [39:0] words;
    logic [12:0] flags;
    logic [2:0] osc;
    logic [1:0] sw;
    logic clk;
    logic [2:0] pair;
    logic [1:0] run;
    logic [15:0] div;
  } row_type;
  // five words, then flags, oscillator, switch, clock out, pin pair, run, divider
  row_type rows [8] = '{
    '{40'hE0FFFFFF83, 13'h1ED0, 3'h0, 2'h0, 1'h1, 3'h1, 2'h3, 16'h8000},
    '{40'h017A400080, 13'h0229, 3'h1, 2'h2, 1'h0, 3'h0, 2'h0, 16'h0001},
    '{40'h4200255F02, 13'h0916, 3'h2, 2'h3, 1'h0, 3'h2, 2'h3, 16'h0020},
    '{40'h23B48FA901, 13'h077C, 3'h3, 2'h0, 1'h1, 3'h4, 2'h0, 16'h8000},
    '{40'h844DB7C283, 13'h11E8, 3'h4, 2'h2, 1'h0, 3'h1, 2'h3, 16'h0080},
    '{40'h05EE01FF80, 13'h0351, 3'h5, 2'h0, 1'h0, 3'h0, 2'h1, 16'h0002},
    '{40'hE6FFFFFF02, 13'h1ED4, 3'h6, 2'h0, 1'h1, 3'h2, 2'h3, 16'h8000},
    '{40'hFFFFFFFFFF, 13'h1ED0, 3'h7, 2'h0, 1'h1, 3'h1, 2'h3, 16'h8000}
  };

  config_word_decoder config_word_decoder_inst (
    .i_mclk, .i_rst, .i_tbl_rd, .i_tbl_wr, .i_tbl_addr, .i_tbl_wdata, .o_tbl_rdata,
    .o_tbl_ack, .i_bulk_erase, .i_hv_prog_entry, .i_sleep, .i_watchdog_sw_enable,
    .i_watchdog_clear_instr, .i_watchdog_window_open, .i_brownout_sw_enable,
    .i_retention_runtime_en, .i_shared_input_pin, .o_two_speed_startup_en(fl[12]),
    .o_slow_rc_high_power(fl[11]), .o_secondary_crystal_en(fl[10]),
    .o_secondary_digital_clk_in_sel, .o_initial_osc_select, .o_clock_switch_en(sw[1]),
    .o_fail_safe_monitor_en(sw[0]), .o_secondary_osc_high_power(fl[9]),
    .o_primary_freq_range, .o_primary_freq_invalid(fl[1]), .o_clock_out_en,
    .o_primary_osc_mode, .o_watchdog_run(run[1]), .o_watchdog_sw_ctrl(ctl[1]),
    .o_watchdog_windowed(fl[8]), .o_watchdog_prescale_128(fl[7]),
    .o_watchdog_postscale_sel(psel), .o_watchdog_postscale_div, .o_watchdog_clear_reset,
    .o_reset_pin_enable(fl[6]), .o_master_reset_req, .o_shared_input_val,
    .o_brownout_level_sel(bor[2:1]), .o_brownout_zero_power(bor[0]),
    .o_brownout_run(run[0]), .o_brownout_sw_ctrl(ctl[0]), .o_i2c_alt_pins(fl[5]),
    .o_powerup_timer_en(fl[4]), .o_retention_avail(fl[3]), .o_retention_active(ret_act),
    .o_debug_en(fl[2]), .o_prog_pin_pair_sel, .o_debug_pin_invalid(fl[0])
  );

  cfg_programmer_model cfg_programmer_model_inst (
    .i_mclk, .o_tbl_rd(i_tbl_rd), .o_tbl_wr(i_tbl_wr), .o_tbl_addr(i_tbl_addr),
    .o_tbl_wdata(i_tbl_wdata), .i_tbl_rdata(o_tbl_rdata), .i_tbl_ack(o_tbl_ack),
    .o_bulk_erase(i_bulk_erase), .o_hv_prog_entry(i_hv_prog_entry)
  );

  initial
  begin
    i_mclk = 1'b0;
    forever #50 i_mclk = ~i_mclk;
  end

  // ==========================================================
  // shared tasks
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // reads compare against d, writes only check the ack
  task automatic xfer(input logic wr, input logic [23:0] a, input logic [7:0] d, input int gap);
    logic [7:0] q;
    logic ok;
    cfg_programmer_model_inst.access(wr, a, d, gap, q, ok);
    chk("ack", 16'h1, 16'(ok));
    if (!wr)
      chk("rdata", 16'(d), 16'(q));
  endtask

  // settings only pick up stored words while reset is high
  task automatic do_reset();
    @(negedge i_mclk);
    i_rst <= 1'b1;
    repeat (2) @(negedge i_mclk);
    i_rst <= 1'b0;
    repeat (2) @(negedge i_mclk);
  endtask

  task automatic clear_pulse(input logic exp);
    @(negedge i_mclk);
    i_watchdog_clear_instr <= 1'b1;
    @(negedge i_mclk);
    i_watchdog_clear_instr <= 1'b0;
    chk("clear_reset", 16'(exp), 16'(o_watchdog_clear_reset));
    @(negedge i_mclk);
    chk("clear_end", 16'h0, 16'(o_watchdog_clear_reset));
  endtask

  // ==========================================================
  // main sequence
  initial
  begin
    row_type r;
    i_rst = 1'b1;
    {i_sleep, i_watchdog_sw_enable, i_watchdog_clear_instr, i_watchdog_window_open} = 4'h0;
    {i_brownout_sw_enable, i_retention_runtime_en, i_shared_input_pin} = 3'h0;
    cfg_programmer_model_inst.erase();
    do_reset();
    for (int k = 0; k < 6; k++)
      xfer(1'b0, 24'hF80006 + 24'(2 * k), k == 0 ? 8'hE7 : k == 4 ? 8'h83 : k == 5 ? 8'h00 : 8'hFF, 0);
    $display("test erased words done");
    cfg_programmer_model_inst.set_hv(1'b1);
    foreach (rows[i])
    begin
      r = rows[i];
      cfg_programmer_model_inst.erase();
      for (int k = 0; k < 5; k++)
        xfer(1'b1, 24'hF80006 + 24'(2 * k), r.words[39 - 8 * k -: 8], i % 3);
      do_reset();
      chk("flags_hi", 16'(r.flags[12:7]), 16'(fl[12:7]));
      chk("flags_lo", 16'(r.flags[6:0]), 16'(fl[6:0]));
      chk("sclk_in", 16'(!r.flags[10]), 16'(o_secondary_digital_clk_in_sel));
      chk("osc", 16'(r.osc), 16'(o_initial_osc_select));
      chk("switch", 16'(r.sw), 16'(sw));
      chk("freq", 16'(r.words[28:27]), 16'(o_primary_freq_range));
      chk("clk_out", 16'(r.clk), 16'(o_clock_out_en));
      chk("mode", 16'(r.words[25:24]), 16'(o_primary_osc_mode));
      chk("run", 16'(r.run), 16'(run));
      chk("div", r.div, o_watchdog_postscale_div);
      chk("psel", 16'(r.words[19:16]), 16'(psel));
      chk("sw_ctrl", 16'({{r.words[23], r.words[21]} == 2'h2, r.words[9:8] == 2'h1}), 16'(ctl));
      chk("bor", 16'({r.words[14:13], r.words[14:13] == 2'h0}), 16'(bor));
      chk("pair", 16'(r.pair), 16'(o_prog_pin_pair_sel));
      chk("mrst", 16'(r.flags[6]), 16'(o_master_reset_req));
      $display("test row %0d done", i);
    end
    xfer(1'b1, 24'hF80006, 8'h00, 0);
    xfer(1'b0, 24'hF80006, 8'h00, 0);
    chk("held", 16'h7, 16'(o_initial_osc_select));
    $display("test hold done");
    cfg_programmer_model_inst.erase();
    cfg_programmer_model_inst.set_hv(1'b0);
    xfer(1'b1, 24'hF8000C, 8'h00, 0);
    xfer(1'b0, 24'hF8000C, 8'h80, 0);
    cfg_programmer_model_inst.set_hv(1'b1);
    xfer(1'b1, 24'hF8000C, 8'h00, 0);
    xfer(1'b0, 24'hF8000C, 8'h00, 0);
    xfer(1'b1, 24'hF80008, 8'h0F, 0);
    xfer(1'b1, 24'hF80008, 8'hF0, 0);
    xfer(1'b0, 24'hF80008, 8'h00, 0);
    xfer(1'b1, 24'hF80010, 8'h00, 0);
    $display("test programming done");
    cfg_programmer_model_inst.erase();
    xfer(1'b1, 24'hF8000A, 8'h00, 0);
    do_reset();
    clear_pulse(1'b0);
    cfg_programmer_model_inst.erase();
    xfer(1'b1, 24'hF8000A, 8'h8F, 0);
    xfer(1'b1, 24'hF8000C, 8'h7F, 0);
    i_shared_input_pin <= 1'b1;
    i_watchdog_sw_enable <= 1'b1;
    do_reset();
    clear_pulse(1'b1);
    chk("shared_in", 16'h1, 16'(o_shared_input_val));
    chk("mrst_off", 16'h0, 16'(o_master_reset_req));
    $display("test watchdog and pin done");
    // active-only watchdog, software brown-out, retention available
    cfg_programmer_model_inst.erase();
    xfer(1'b1, 24'hF8000A, 8'h2F, 0);
    xfer(1'b1, 24'hF8000C, 8'hF9, 0);
    do_reset();
    chk("run_awake", 16'h2, 16'(run));
    chk("ret_awake", 16'h0, 16'(ret_act));
    i_sleep <= 1'b1;
    i_retention_runtime_en <= 1'b1;
    @(negedge i_mclk);
    chk("run_sleep", 16'h0, 16'(run));
    chk("ret_sleep", 16'h1, 16'(ret_act));
    i_brownout_sw_enable <= 1'b1;
    @(negedge i_mclk);
    chk("bor_sw", 16'h1, 16'(run));
    $display("test sleep controls done");
    complete_run();
  end

  // hang guard: the full run needs well under 1000 cycles
  initial
  begin
    #1000000;
    n_mismatch++;
    complete_run();
  end
endmodule // config_word_decoder_bench
